// >>> hw/mbmac_map.svh
// Purpose: Address map and fixed figures of the memory access control block
// Assumes: 21-bit physical byte addresses, one byte per access
// Notes: Definitions only
`ifndef MBMAC_MAP_SVH
`define MBMAC_MAP_SVH
`define MBMAC_ROM_BASE 21'h000000
`define MBMAC_ROM_SIZE 21'h02e000
`define MBMAC_FLASH_BASE 21'h040000
`define MBMAC_FLASH_SIZE 21'h130000
`define MBMAC_FLASH_RSVD 21'h008000
`define MBMAC_EE_BASE 21'h180000
`define MBMAC_EE_SIZE 21'h020000
`define MBMAC_EE_RSVD 21'h000300
`define MBMAC_MANUF_BASE 21'h19fd00
`define MBMAC_MANUF_SIZE 21'h000300
`define MBMAC_MANUF_BLK_SH 6
`define MBMAC_RAM_BASE 21'h1c0000
`define MBMAC_RAM_RSVD 21'h000200
`define MBMAC_GP_OFS 21'h000200
`define MBMAC_GP_SIZE 21'h007e00
`define MBMAC_SHR_OFS 21'h008000
`define MBMAC_SHR_SIZE 21'h000a80
`define MBMAC_SFR_BASE 21'h1f0000
`define MBMAC_SFR_HW_BIT 7
`endif

// >>> hw/mbmac_pkg.sv
// Purpose: Types of the memory access control block
// Assumes: Addresses are physical byte addresses
// Notes: Constants live in mbmac_map.svh
package mbmac_pkg;
  typedef enum logic [4:0] {
    MODE_BOOT = 5'h01,
    MODE_TEST = 5'h02,
    MODE_FW = 5'h04,
    MODE_SYS = 5'h08,
    MODE_USER = 5'h10
  } mbmac_mode_t;
  typedef enum logic [1:0] {ACC_READ = 2'h0, ACC_WRITE = 2'h1, ACC_EXEC = 2'h2} mbmac_acc_t;
  typedef enum logic [1:0] {SPC_MEM = 2'h0, SPC_SFR = 2'h1, SPC_EXT = 2'h2} mbmac_spc_t;
  typedef enum logic [1:0] {EP_SWP = 2'h0, EP_EXT = 2'h1, EP_OTHER = 2'h2} mbmac_ep_t;
  typedef struct packed {
    logic valid;
    mbmac_acc_t acc;
    mbmac_spc_t spc;
    logic [20:0] addr;
    logic [7:0] wdata;
  } mbmac_req_t;
  typedef struct packed {
    logic done;
    logic viol;
    logic [7:0] rdata;
  } mbmac_rsp_t;
  typedef struct packed {
    logic valid;
    logic we;
    logic [20:0] addr;
    logic [7:0] wdata;
  } mbmac_cmd_t;
  typedef struct packed {
    logic valid;
    logic we;
    logic [11:0] ofs;
    logic [7:0] wdata;
  } mbmac_cop_t;
  typedef struct packed {
    logic valid;
    mbmac_ep_t src;
    mbmac_ep_t dst;
    logic [14:0] xofs;
  } mbmac_fdcm_t;
  typedef struct packed {
    logic en;
    logic xmap;
    logic [20:0] base;
    logic [20:0] size;
    logic [20:0] phys;
    logic rd;
    logic wr;
    logic ex;
  } mbmac_seg_t;
  typedef struct packed {
    logic hit;
    logic rd;
    logic wr;
    logic ex;
    logic [20:0] phys;
  } mbmac_hit_t;
endpackage

// >>> hw/mbmac_seg_match.sv
// Purpose: Software segment lookup for user mode accesses
// Assumes: Segments do not need to be disjoint
// Notes: Lowest matching segment wins; combinational
`timescale 1ns/1ns
`default_nettype none
module mbmac_seg_match #(
  parameter int NSEG = 8
) (
  // Lookup
  input wire logic [20:0] addr,
  input wire logic ext_data,
  input wire mbmac_pkg::mbmac_seg_t [NSEG-1:0] seg_cfg,
  // Result
  output var mbmac_pkg::mbmac_hit_t res
);
  logic [NSEG-1:0] hit;
  logic [NSEG-1:0][20:0] rel;
  genvar g;
  generate
    for (g = 0; g < NSEG; g++)
    begin : g_seg
      // Mapping segments serve only the virtual range, plain ones only physical
      assign rel[g] = addr - seg_cfg[g].base;
      assign hit[g] = seg_cfg[g].en && (seg_cfg[g].xmap == ext_data) &&
                      (addr >= seg_cfg[g].base) && (rel[g] < seg_cfg[g].size);
    end
  endgenerate
  always_comb
  begin
    res = '0;
    for (int i = NSEG - 1; i >= 0; i--)
    begin
      if (hit[i])
      begin
        res.hit = 1'b1;
        res.rd = seg_cfg[i].rd;
        res.wr = seg_cfg[i].wr;
        res.ex = seg_cfg[i].ex;
        res.phys = ext_data ? seg_cfg[i].phys + rel[i] : addr;
      end
    end
  end
endmodule // mbmac_seg_match
`default_nettype wire

// >>> hw/mbmac_top.sv
// Purpose: Mode based memory and register access control
// Assumes: CPU keeps one request outstanding until cpu_rsp_q.done
// Notes: Overview of operation below
`include "mbmac_map.svh"
`timescale 1ns/1ns
`default_nettype none
module mbmac_top #(
  parameter int NSEG = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Mode and configuration
  input wire mbmac_pkg::mbmac_mode_t cpu_mode,
  input wire mbmac_pkg::mbmac_seg_t [NSEG-1:0] seg_cfg,
  input wire logic [7:0] sfr_grant,
  input wire logic fw_check_en,
  input wire logic [11:0] manuf_open,
  // CPU side
  input wire mbmac_pkg::mbmac_req_t cpu_req,
  output var mbmac_pkg::mbmac_rsp_t cpu_rsp_q,
  output var logic exc_violation_q,
  // Memory side
  output var mbmac_pkg::mbmac_cmd_t mem_cmd_q,
  input wire logic mem_rvalid,
  input wire logic [7:0] mem_rdata,
  // Coprocessor shared RAM
  input wire mbmac_pkg::mbmac_cop_t cop_req,
  output var mbmac_pkg::mbmac_cmd_t shr_cmd_q,
  // Copy engine
  input wire mbmac_pkg::mbmac_fdcm_t fdcm_req,
  output var logic fdcm_grant_q,
  output var logic fdcm_deny_q,
  output var logic [20:0] fdcm_addr_q
);
  function automatic logic in_rng(input logic [20:0] a, input logic [20:0] b,
                                  input logic [20:0] s);
    logic [20:0] r;
    r = a - b;
    return (a >= b) && (r < s);
  endfunction

  // Mode decode
  wire logic is_boot = (cpu_mode == mbmac_pkg::MODE_BOOT);
  wire logic is_test = (cpu_mode == mbmac_pkg::MODE_TEST);
  wire logic is_fw = (cpu_mode == mbmac_pkg::MODE_FW);
  wire logic is_sys = (cpu_mode == mbmac_pkg::MODE_SYS);
  wire logic is_user = (cpu_mode == mbmac_pkg::MODE_USER);
  wire logic is_rd = (cpu_req.acc == mbmac_pkg::ACC_READ);
  wire logic is_wr = (cpu_req.acc == mbmac_pkg::ACC_WRITE);
  wire logic is_ex = (cpu_req.acc == mbmac_pkg::ACC_EXEC);
  wire logic sp_sfr = (cpu_req.spc == mbmac_pkg::SPC_SFR);
  wire logic sp_x = (cpu_req.spc == mbmac_pkg::SPC_EXT);
  wire logic [20:0] sfr_phys = `MBMAC_SFR_BASE + {13'h0, cpu_req.addr[7:0]};

  // Extended data translation
  wire logic [20:0] gp_base = `MBMAC_RAM_BASE + `MBMAC_GP_OFS;
  wire logic [20:0] x_fix = gp_base + cpu_req.addr;
  wire logic x_fix_ok = (cpu_req.addr < `MBMAC_GP_SIZE);
  mbmac_pkg::mbmac_hit_t seg;
  mbmac_seg_match #(
    .NSEG(NSEG)
  ) u_seg (
    .addr(sp_sfr ? sfr_phys : cpu_req.addr),
    .ext_data(sp_x),
    .seg_cfg(seg_cfg),
    .res(seg)
  );
  // Software mapping applies only to user mode; the rest see fixed RAM
  wire logic x_ok = is_user ? seg.hit : x_fix_ok;
  wire logic [20:0] x_phys = is_user ? seg.phys : x_fix;
  wire logic [20:0] eff = sp_x ? x_phys :
                          sp_sfr ? sfr_phys :
                          cpu_req.addr;

  // Region decode
  wire logic r_rom = !sp_sfr && in_rng(eff, `MBMAC_ROM_BASE, `MBMAC_ROM_SIZE);
  wire logic r_fl = !sp_sfr && in_rng(eff, `MBMAC_FLASH_BASE, `MBMAC_FLASH_SIZE);
  wire logic r_ee = !sp_sfr && in_rng(eff, `MBMAC_EE_BASE, `MBMAC_EE_SIZE);
  wire logic r_ram = !sp_sfr &&
    in_rng(eff, `MBMAC_RAM_BASE, `MBMAC_SHR_OFS + `MBMAC_SHR_SIZE);
  wire logic r_rsvd = r_rom ||
    in_rng(eff, `MBMAC_FLASH_BASE, `MBMAC_FLASH_RSVD) ||
    in_rng(eff, `MBMAC_EE_BASE, `MBMAC_EE_RSVD) ||
    in_rng(eff, `MBMAC_RAM_BASE, `MBMAC_RAM_RSVD);
  wire logic r_man = in_rng(eff, `MBMAC_MANUF_BASE, `MBMAC_MANUF_SIZE);
  wire logic r_app = (r_fl || r_ee || r_ram) && !r_rsvd && !r_man;
  wire logic r_appnv = (r_fl || r_ee) && !r_rsvd;
  wire logic [20:0] man_rel = eff - `MBMAC_MANUF_BASE;
  wire logic [3:0] man_blk = man_rel[`MBMAC_MANUF_BLK_SH+3:`MBMAC_MANUF_BLK_SH];
  wire logic man_open = (man_blk < 4'hc) && manuf_open[man_blk];
  wire logic sfr_hw = sp_sfr && cpu_req.addr[`MBMAC_SFR_HW_BIT];
  wire logic sfr_core = sp_sfr && !cpu_req.addr[`MBMAC_SFR_HW_BIT];
  wire logic sfr_ok = sfr_grant[cpu_req.addr[6:4]];
  wire logic seg_perm = seg.hit && ((is_rd && seg.rd) || (is_wr && seg.wr) ||
                        (is_ex && seg.ex));
  wire logic x_bad = sp_x && !x_ok;

  // Per-mode decisions
  wire logic ok_test = r_rom || r_fl || r_ee || r_ram || sp_sfr;
  wire logic ok_boot = r_rsvd || sp_sfr;
  wire logic ok_fw = r_rsvd || r_man || sfr_core || (sfr_hw && sfr_ok) ||
                     (r_appnv && !r_man && is_rd && fw_check_en);
  wire logic ok_sys = r_app || sp_sfr || (r_man && is_rd && man_open);
  wire logic ok_user = (r_app && seg_perm) ||
                       (r_man && is_rd && man_open && seg_perm) ||
                       (sfr_hw && sfr_ok && seg_perm);
  wire logic ok_mode = is_test ? ok_test : is_boot ? ok_boot : is_fw ? ok_fw :
                       is_sys ? ok_sys : is_user && ok_user;
  wire logic allow = ok_mode && !x_bad && !(sp_sfr && is_ex);
  wire logic req_go = ce && cpu_req.valid;

  // CPU path
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mem_cmd_q <= '0;
      cpu_rsp_q <= '0;
      exc_violation_q <= 1'b0;
    end
    else if (ce)
    begin
      mem_cmd_q.valid <= cpu_req.valid && allow;
      mem_cmd_q.we <= is_wr;
      mem_cmd_q.addr <= eff;
      mem_cmd_q.wdata <= cpu_req.wdata;
      // Refused reads return zero so no protected byte reaches the CPU
      cpu_rsp_q.done <= (cpu_req.valid && !(allow && !is_wr)) || mem_rvalid;
      cpu_rsp_q.viol <= cpu_req.valid && !allow;
      cpu_rsp_q.rdata <= mem_rvalid ? mem_rdata : 8'h00;
      exc_violation_q <= cpu_req.valid && !allow;
    end
  end

  // Coprocessor path bypasses every mode check by design
  wire logic cop_in = (cop_req.ofs < `MBMAC_SHR_SIZE);
  wire logic [20:0] cop_addr = `MBMAC_RAM_BASE + `MBMAC_SHR_OFS + {9'h000, cop_req.ofs};
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      shr_cmd_q <= '0;
    else if (ce)
    begin
      shr_cmd_q.valid <= cop_req.valid && cop_in;
      shr_cmd_q.we <= cop_req.we;
      shr_cmd_q.addr <= cop_addr;
      shr_cmd_q.wdata <= cop_req.wdata;
    end
  end

  // Copy engine
  wire logic fd_pair = ((fdcm_req.src == mbmac_pkg::EP_SWP) &&
                        (fdcm_req.dst == mbmac_pkg::EP_EXT)) ||
                       ((fdcm_req.src == mbmac_pkg::EP_EXT) &&
                        (fdcm_req.dst == mbmac_pkg::EP_SWP));
  wire logic fd_ok = fd_pair && (fdcm_req.xofs < `MBMAC_GP_SIZE);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fdcm_grant_q <= 1'b0;
      fdcm_deny_q <= 1'b0;
      fdcm_addr_q <= '0;
    end
    else if (ce)
    begin
      fdcm_grant_q <= fdcm_req.valid && fd_ok;
      fdcm_deny_q <= fdcm_req.valid && !fd_ok;
      fdcm_addr_q <= gp_base + {6'h00, fdcm_req.xofs};
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Out-of-range extended data offsets are refused in every mode, so they are excluded
  a_test_full_access: assert property (req_go && is_test && r_app && !x_bad
    |=> mem_cmd_q.valid)
    else $error("test mode access to application memory refused");
  a_boot_app_denied: assert property (req_go && is_boot && r_app |=> exc_violation_q)
    else $error("boot mode reached application memory");
  a_fw_integrity: assert property (req_go && is_fw && r_appnv && is_rd && !r_man
    |=> mem_cmd_q.valid == $past(fw_check_en))
    else $error("firmware integrity read not following enable");
  a_user_default: assert property (req_go && is_user && r_app && !seg.hit
    |=> cpu_rsp_q.viol && !mem_cmd_q.valid)
    else $error("user access without segment allowed");
  a_sys_app_full: assert property (req_go && is_sys && r_app && !x_bad
    |=> !exc_violation_q)
    else $error("system mode refused application memory");
  a_rsvd_isolated: assert property (req_go && (is_sys || is_user) && r_rsvd
    |=> exc_violation_q)
    else $error("reserved partition reached from application mode");
  a_ext_fixed: assert property (req_go && is_sys && sp_x && x_fix_ok
    |=> mem_cmd_q.addr == gp_base + $past(cpu_req.addr))
    else $error("extended data not mapped to general RAM");
  a_cop_direct: assert property (ce && cop_req.valid && cop_in |=> shr_cmd_q.valid)
    else $error("coprocessor shared RAM request dropped");
  a_fdcm_swp_only: assert property (ce && fdcm_req.valid && !fd_pair
    |=> fdcm_deny_q && !fdcm_grant_q)
    else $error("copy engine reached foreign endpoint");
  a_viol_suppress: assert property (exc_violation_q |-> !mem_cmd_q.valid &&
    cpu_rsp_q.rdata == 8'h00)
    else $error("refused access reached memory");
  a_sfr_grant: assert property (req_go && (is_user || is_fw) && sfr_hw && !sfr_ok
    |=> exc_violation_q)
    else $error("hardware register reached without grant");
  c_user_seg_hit: cover property (req_go && is_user && r_app && seg_perm ##1 mem_cmd_q.valid);
  c_fw_check: cover property (req_go && is_fw && fw_check_en && r_appnv);
  c_fdcm_ok: cover property (ce && fdcm_req.valid ##1 fdcm_grant_q);
  c_user_ext: cover property (req_go && is_user && sp_x && seg.hit);
endmodule // mbmac_top
`default_nettype wire

// >>> tb/mbmac_mem_model.sv
// Purpose: Behavioural memory stand-in behind the access control block, without storage
// Assumes: One read outstanding at a time; answer after lat idle cycles
// Notes: Data lines toggle while idle so a stale value never passes
`timescale 1ns/1ns
`default_nettype none
module mbmac_mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Command and answer
  input wire mbmac_pkg::mbmac_cmd_t cmd,
  input wire logic [3:0] lat,
  output var logic rvalid,
  output var logic [7:0] rdata
);
  logic busy_q;
  logic [3:0] cnt_q;
  logic [7:0] dat_q;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
      dat_q <= 8'h00;
      rvalid <= 1'b0;
      rdata <= 8'h00;
    end
    else
    begin
      rvalid <= 1'b0;
      rdata <= ~rdata;
      if (cmd.valid && !cmd.we)
      begin
        busy_q <= 1'b1;
        cnt_q <= lat;
        dat_q <= ~cmd.addr[7:0];
      end
      else if (busy_q && cnt_q != 4'h0)
        cnt_q <= cnt_q - 4'h1;
      else if (busy_q)
      begin
        busy_q <= 1'b0;
        rvalid <= 1'b1;
        rdata <= dat_q;
      end
    end
  end
endmodule // mbmac_mem_model
`default_nettype wire

// >>> tb/testbench.sv
// Purpose: Self-checking bench of the memory access control block
// Assumes: Inputs change at the falling edge; two segments
// Notes: Read data from the model is the inverted low address byte
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  mbmac_pkg::mbmac_mode_t cpu_mode = mbmac_pkg::MODE_SYS;
  mbmac_pkg::mbmac_seg_t [1:0] seg_cfg = '0;
  logic [7:0] sfr_grant = 8'h00;
  logic fw_check_en = 1'b0;
  logic [11:0] manuf_open = 12'h000;
  mbmac_pkg::mbmac_req_t cpu_req = '0;
  mbmac_pkg::mbmac_rsp_t cpu_rsp_q;
  logic exc_violation_q;
  mbmac_pkg::mbmac_cmd_t mem_cmd_q;
  logic mem_rvalid;
  logic [7:0] mem_rdata;
  mbmac_pkg::mbmac_cop_t cop_req = '0;
  mbmac_pkg::mbmac_cmd_t shr_cmd_q;
  mbmac_pkg::mbmac_fdcm_t fdcm_req = '0;
  logic fdcm_grant_q;
  logic fdcm_deny_q;
  logic [20:0] fdcm_addr_q;
  logic [3:0] lat = 4'h0;
  logic ce = 1'b1;
  int miscompares = 0;
  int n_tests = 0;
  always #2 clk = ~clk;
  mbmac_top #(.NSEG(2)) mbmac_top_inst (.clk(clk), .rst(rst), .ce(ce), .cpu_mode(cpu_mode),
    .seg_cfg(seg_cfg), .sfr_grant(sfr_grant), .fw_check_en(fw_check_en),
    .manuf_open(manuf_open), .cpu_req(cpu_req), .cpu_rsp_q(cpu_rsp_q),
    .exc_violation_q(exc_violation_q), .mem_cmd_q(mem_cmd_q), .mem_rvalid(mem_rvalid),
    .mem_rdata(mem_rdata), .cop_req(cop_req), .shr_cmd_q(shr_cmd_q), .fdcm_req(fdcm_req),
    .fdcm_grant_q(fdcm_grant_q), .fdcm_deny_q(fdcm_deny_q), .fdcm_addr_q(fdcm_addr_q));
  mbmac_mem_model mbmac_mem_model_inst (.clk(clk), .rst(rst), .cmd(mem_cmd_q), .lat(lat),
    .rvalid(mem_rvalid), .rdata(mem_rdata));
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // One CPU byte access; ev expects refusal, ea the physical address issued
  task automatic acc(input logic [1:0] a, input logic [1:0] s, input logic [20:0] ad,
    input logic ev, input logic [20:0] ea);
    logic [29:0] seen;
    seen = '1;
    cpu_req = '{1'b1, mbmac_pkg::mbmac_acc_t'(a), mbmac_pkg::mbmac_spc_t'(s), ad, 8'h3c};
    @(negedge clk);
    cpu_req.valid = 1'b0;
    for (int i = 0; i < 24; i++)
    begin
      if (mem_cmd_q.valid === 1'b1)
        seen = {mem_cmd_q.we, mem_cmd_q.wdata, mem_cmd_q.addr};
      if (cpu_rsp_q.done === 1'b1)
        break;
      @(negedge clk);
    end
    `CHK("done", 1'b1, cpu_rsp_q.done)
    `CHK("viol", ev, cpu_rsp_q.viol)
    `CHK("exc", ev, exc_violation_q)
    if (!ev)
      `CHK("cmd", {a == 2'h1, 8'h3c, ea}, seen)
    if (!ev && a != 2'h1)
      `CHK("rdata", ~ea[7:0], cpu_rsp_q.rdata)
    if (ev)
      `CHK("rdata", 8'h00, cpu_rsp_q.rdata)
    @(negedge clk);
  endtask
  task automatic s_modes;
    acc(2'h0, 2'h0, 21'h050000, 1'b0, 21'h050000);
    acc(2'h1, 2'h0, 21'h1c0300, 1'b0, 21'h1c0300);
    cpu_mode = mbmac_pkg::MODE_TEST;
    acc(2'h1, 2'h0, 21'h050001, 1'b0, 21'h050001);
    cpu_mode = mbmac_pkg::MODE_BOOT;
    acc(2'h0, 2'h0, 21'h050000, 1'b1, 21'h0);
    acc(2'h0, 2'h0, 21'h000100, 1'b0, 21'h000100);
    cpu_mode = mbmac_pkg::MODE_FW;
    acc(2'h2, 2'h0, 21'h050000, 1'b1, 21'h0);
    fw_check_en = 1'b1;
    acc(2'h0, 2'h0, 21'h050002, 1'b0, 21'h050002);
    acc(2'h1, 2'h0, 21'h050002, 1'b1, 21'h0);
    acc(2'h0, 2'h1, 21'h000080, 1'b1, 21'h0);
    sfr_grant = 8'h01;
    acc(2'h0, 2'h1, 21'h000085, 1'b0, 21'h1f0085);
    cpu_mode = mbmac_pkg::MODE_USER;
    acc(2'h0, 2'h0, 21'h050000, 1'b1, 21'h0);
    cpu_mode = mbmac_pkg::mbmac_mode_t'(5'h03);
    acc(2'h0, 2'h0, 21'h050000, 1'b1, 21'h0);
  endtask
  task automatic s_reserved;
    cpu_mode = mbmac_pkg::MODE_SYS;
    acc(2'h0, 2'h0, 21'h000100, 1'b1, 21'h0);
    acc(2'h0, 2'h0, 21'h047fff, 1'b1, 21'h0);
    acc(2'h0, 2'h0, 21'h048000, 1'b0, 21'h048000);
    acc(2'h0, 2'h0, 21'h1802ff, 1'b1, 21'h0);
    acc(2'h1, 2'h0, 21'h1c01ff, 1'b1, 21'h0);
    acc(2'h2, 2'h1, 21'h000010, 1'b1, 21'h0);
    acc(2'h0, 2'h2, 21'h000010, 1'b0, 21'h1c0210);
    acc(2'h0, 2'h2, 21'h007dff, 1'b0, 21'h1c7fff);
    acc(2'h0, 2'h2, 21'h007e00, 1'b1, 21'h0);
    acc(2'h0, 2'h0, 21'h19fd00, 1'b1, 21'h0);
    manuf_open = 12'h001;
    acc(2'h0, 2'h0, 21'h19fd3f, 1'b0, 21'h19fd3f);
    acc(2'h0, 2'h0, 21'h19fd40, 1'b1, 21'h0);
  endtask
  task automatic s_user;
    lat = 4'h5;
    seg_cfg[0] = '{1'b1, 1'b0, 21'h1c0200, 21'h000100, 21'h0, 1'b1, 1'b0, 1'b0};
    seg_cfg[1] = '{1'b1, 1'b1, 21'h0, 21'h000100, 21'h1c0400, 1'b1, 1'b1, 1'b0};
    cpu_mode = mbmac_pkg::MODE_USER;
    acc(2'h0, 2'h0, 21'h1c02ff, 1'b0, 21'h1c02ff);
    acc(2'h0, 2'h0, 21'h1c0300, 1'b1, 21'h0);
    acc(2'h1, 2'h0, 21'h1c0200, 1'b1, 21'h0);
    acc(2'h0, 2'h2, 21'h000020, 1'b0, 21'h1c0420);
    acc(2'h0, 2'h2, 21'h000100, 1'b1, 21'h0);
    seg_cfg[0].wr = 1'b1;
    acc(2'h1, 2'h0, 21'h1c0200, 1'b0, 21'h1c0200);
    seg_cfg[0] = '{1'b1, 1'b0, 21'h1f0080, 21'h000020, 21'h0, 1'b1, 1'b0, 1'b0};
    acc(2'h0, 2'h1, 21'h000085, 1'b0, 21'h1f0085);
    acc(2'h0, 2'h1, 21'h000095, 1'b1, 21'h0);
  endtask
  // A request offered while the clock enable is low must wait
  task automatic s_hold;
    cpu_mode = mbmac_pkg::MODE_SYS;
    ce = 1'b0;
    cpu_req = '{1'b1, mbmac_pkg::ACC_READ, mbmac_pkg::SPC_MEM, 21'h000100, 8'h3c};
    repeat (2) @(negedge clk);
    `CHK("ce_hold", 1'b0, exc_violation_q)
    ce = 1'b1;
    @(negedge clk);
    cpu_req.valid = 1'b0;
    `CHK("ce_run", 1'b1, exc_violation_q)
    @(negedge clk);
  endtask
  // Coprocessor and copy engine run while the CPU sits in user mode
  task automatic s_paths;
    logic [5:0] pairs[4] = '{6'h21, 6'h24, 6'h10, 6'h1e};
    cop_req = '{1'b1, 1'b1, 12'h005, 8'h77};
    @(negedge clk);
    cop_req.ofs = 12'ha80;
    `CHK("shr", 22'h3c8005, {shr_cmd_q.valid, shr_cmd_q.addr})
    @(negedge clk);
    cop_req.valid = 1'b0;
    `CHK("shr_drop", 1'b0, shr_cmd_q.valid)
    foreach (pairs[k])
    begin
      fdcm_req = '{1'b1, mbmac_pkg::mbmac_ep_t'(pairs[k][3:2]),
        mbmac_pkg::mbmac_ep_t'(pairs[k][1:0]), 15'h0040};
      @(negedge clk);
      fdcm_req.valid = 1'b0;
      `CHK("fdcm", pairs[k][5:4], {fdcm_grant_q, fdcm_deny_q})
      if (pairs[k][5])
        `CHK("fdcm_addr", 21'h1c0240, fdcm_addr_q)
      @(negedge clk);
    end
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    `CHK("reset", 15'h0000, {cpu_rsp_q, exc_violation_q, mem_cmd_q.valid, shr_cmd_q.valid,
      fdcm_grant_q, fdcm_deny_q})
    s_modes();
    s_reserved();
    s_user();
    s_paths();
    s_hold();
    results();
  end
  initial
  begin
    #40000;
    miscompares++;
    results();
  end
endmodule // testbench
`default_nettype wire
